//--- pin_select_pkg.sv
// Package of constants for the host / PCI / Ethernet shared pin selector
package pin_select_pkg;
  // ==========================================================
  // Pin group widths
  localparam int HOST_DATA_WIDTH = 32;
  localparam int PCI_SOLO_WIDTH = 8;
  localparam int EXT_ADDR_WIDTH = 19;
  // ==========================================================
  // Masks over the 32 shared data pins
  localparam logic [31:0] PCI_LOW_MASK = 32'h0080_ffff;   // Bits 23 and 15:0
  localparam logic [31:0] MII_MASK = 32'hff7f_0000;       // Bits 31:24 and 22:16
  // MII direction: receive group 31:24 and 22 (tx clock) are inputs, 21 collision input
  localparam logic [31:0] MII_OUT_MASK = 32'h001f_0000;   // Bits 20:16 driven by the MAC
  // ==========================================================
  // Reset values of latched straps, and the expected address-bus default
  localparam logic PCI_STRAP_RESET = 1'b0;
  localparam logic ETH_STRAP_RESET = 1'b0;
  localparam logic [18:0] EXT_ADDR_DEFAULT = 19'h00000;
  // ==========================================================
  // Peripheral-select value of the documented example configuration
  localparam logic [31:0] PERIPH_SELECT_EXAMPLE = 32'h0000_0078;
endpackage

//--- host_pci_mii_pin_select.sv
// Strap-selected function mux for the shared host-port, PCI and MII pins
// Functional notes
// - PCI strap low: host-port data, PCI off
// - PCI strap high: data pins not taken by MII become PCI
// - Ethernet strap high: MII on upper data pins
// - PCI off: standalone PCI pins high impedance
// - Example straps give documented peripheral set
// - Ethernet strap also routes management pins
`timescale 1ns/1ns
module host_pci_mii_pin_select (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_pci_select_strap,
  input wire logic i_ethernet_select_strap,
  input wire logic i_eeprom_autoinit_strap,
  input wire logic i_host_data_bit_five,
  input wire logic [31:0] i_peripheral_select_register,
  input wire logic [31:0] i_host_port_data_in,
  input wire logic [31:0] i_host_port_data_out,
  input wire logic [31:0] i_host_port_data_oe,
  input wire logic [31:0] i_pci_ad_out,
  input wire logic [31:0] i_pci_ad_oe,
  input wire logic [4:0] i_mii_tx_out,
  input wire logic [7:0] i_pci_solo_out,
  input wire logic [7:0] i_pci_solo_oe,
  input wire logic i_mgmt_clock,
  input wire logic i_mgmt_data_out,
  input wire logic i_mgmt_data_oe,
  input wire logic [18:0] i_external_address_bus,
  output logic [31:0] o_host_port_data_out,
  output logic [31:0] o_host_port_data_oe,
  output logic [31:0] o_host_port_data_to_core,
  output logic [31:0] o_pci_ad_to_core,
  output logic [10:0] o_mii_rx_to_core,
  output logic [7:0] o_pci_solo_out,
  output logic [7:0] o_pci_solo_oe,
  output logic o_expansion_serial_clock_out,
  output logic o_expansion_serial_data_out,
  output logic o_expansion_serial_data_oe,
  output logic o_host_port_enable,
  output logic o_pci_enable,
  output logic o_ethernet_controller_enable,
  output logic o_example_config_match,
  output logic o_external_address_violation
);
  // ==========================================================
  // Strap capture
  logic pci_sel_reg;       // Latched PCI strap
  logic eth_sel_reg;       // Latched Ethernet strap
  logic captured_reg;      // Set after the one capture
  logic eeprom_sel_reg;    // Latched autoinit strap
  logic hd5_sel_reg;       // Latched host data bit five

  // Capture on the first edge after release, then hold: the async reset
  // may only load constants, so the strap is sampled by a clocked step
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pci_sel_reg <= pin_select_pkg::PCI_STRAP_RESET;
      eth_sel_reg <= pin_select_pkg::ETH_STRAP_RESET;
      eeprom_sel_reg <= 1'b0;
      hd5_sel_reg <= 1'b0;
      captured_reg <= 1'b0;
    end else if (!captured_reg) begin
      pci_sel_reg <= i_pci_select_strap;
      eth_sel_reg <= i_ethernet_select_strap;
      eeprom_sel_reg <= i_eeprom_autoinit_strap;
      hd5_sel_reg <= i_host_data_bit_five;
      captured_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Per-pin owner masks
  logic [31:0] pci_mask;   // Pins owned by PCI
  logic [31:0] mii_mask;   // Pins owned by MII
  logic [31:0] mii_drive;  // MII pins driven outward
  logic [31:0] mii_tx_word; // MII transmit bits placed on the bus

  // Ethernet takes its pins ahead of PCI; PCI keeps the low group
  always_comb begin
    mii_mask = (captured_reg && eth_sel_reg) ? pin_select_pkg::MII_MASK : 32'h0000_0000;
    pci_mask = (captured_reg && pci_sel_reg) ? ~mii_mask : 32'h0000_0000;
    mii_drive = mii_mask & pin_select_pkg::MII_OUT_MASK;
    mii_tx_word = {11'h000, i_mii_tx_out, 16'h0000};
  end

  // ==========================================================
  // Shared data pin drive, registered
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_host_port_data_out <= 32'h0000_0000;
      o_host_port_data_oe <= 32'h0000_0000;
    end else begin
      // Each pin takes value and enable from its owner only
      o_host_port_data_out <= (pci_mask & i_pci_ad_out) | (mii_drive & mii_tx_word)
                              | (~pci_mask & ~mii_mask & i_host_port_data_out);
      o_host_port_data_oe <= (pci_mask & i_pci_ad_oe) | mii_drive
                             | (~pci_mask & ~mii_mask & i_host_port_data_oe);
    end
  end

  // ==========================================================
  // Pin inputs steered to the owning core; others see zero
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_host_port_data_to_core <= 32'h0000_0000;
      o_pci_ad_to_core <= 32'h0000_0000;
      o_mii_rx_to_core <= 11'h000;
    end else begin
      o_host_port_data_to_core <= i_host_port_data_in & ~pci_mask & ~mii_mask;
      o_pci_ad_to_core <= i_host_port_data_in & pci_mask;
      // Receive group 31:24, then bits 22:20: tx clock 22, collision 21 and bit 20
      o_mii_rx_to_core <= eth_sel_reg ? {i_host_port_data_in[31:24], i_host_port_data_in[22:20]} : 11'h000;
    end
  end

  // ==========================================================
  // Standalone PCI pins and management pins
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pci_solo_out <= 8'h00;
      o_pci_solo_oe <= 8'h00;
      o_expansion_serial_clock_out <= 1'b0;
      o_expansion_serial_data_out <= 1'b0;
      o_expansion_serial_data_oe <= 1'b0;
    end else begin
      // PCI off: enables forced low so the pins float
      o_pci_solo_out <= (captured_reg && pci_sel_reg) ? i_pci_solo_out : 8'h00;
      o_pci_solo_oe <= (captured_reg && pci_sel_reg) ? i_pci_solo_oe : 8'h00;
      o_expansion_serial_clock_out <= captured_reg && eth_sel_reg && i_mgmt_clock;
      o_expansion_serial_data_out <= captured_reg && eth_sel_reg && i_mgmt_data_out;
      o_expansion_serial_data_oe <= captured_reg && eth_sel_reg && i_mgmt_data_oe;
    end
  end

  // ==========================================================
  // Status outputs
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_host_port_enable <= 1'b0;
      o_pci_enable <= 1'b0;
      o_ethernet_controller_enable <= 1'b0;
      o_example_config_match <= 1'b0;
      o_external_address_violation <= 1'b0;
    end else begin
      o_host_port_enable <= captured_reg && !pci_sel_reg;
      o_pci_enable <= captured_reg && pci_sel_reg;
      o_ethernet_controller_enable <= captured_reg && eth_sel_reg;
      // Example set: video, host port, Ethernet, management, I2C, memory, timers
      o_example_config_match <= captured_reg && !pci_sel_reg && !eeprom_sel_reg && !hd5_sel_reg && eth_sel_reg
                                && (i_peripheral_select_register == pin_select_pkg::PERIPH_SELECT_EXAMPLE);
      // Sticky flag, only a diagnostic: an outside agent fought the defaults
      if (!captured_reg && i_external_address_bus != pin_select_pkg::EXT_ADDR_DEFAULT)
        o_external_address_violation <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  sequence capture_s;
    !captured_reg ##1 captured_reg;
  endsequence

  strap_hold_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    captured_reg |=> $stable(pci_sel_reg) && $stable(eth_sel_reg)) else $error("strap changed");
  strap_take_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    capture_s |-> pci_sel_reg == $past(i_pci_select_strap)) else $error("strap not captured");
  pci_off_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !pci_sel_reg ##1 1'b1 |-> o_pci_solo_oe == 8'h00) else $error("pci pin driven");
  host_own_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    captured_reg && !pci_sel_reg && !eth_sel_reg |=> o_host_port_data_oe == $past(i_host_port_data_oe))
    else $error("host data not routed");
  pci_route_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    captured_reg && pci_sel_reg && !eth_sel_reg |=> o_host_port_data_out == $past(i_pci_ad_out))
    else $error("pci data not routed");
  mii_route_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    captured_reg && eth_sel_reg |=> o_host_port_data_out[20:16] == $past(i_mii_tx_out)
    && o_host_port_data_oe[31:24] == 8'h00 && o_host_port_data_oe[22:21] == 2'h0)
    else $error("mii not routed");
  mgmt_pin_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    captured_reg && eth_sel_reg |=> o_expansion_serial_clock_out == $past(i_mgmt_clock)
    && o_ethernet_controller_enable) else $error("management pin wrong");
  example_cfg_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    o_example_config_match |-> o_ethernet_controller_enable && o_host_port_enable) else $error("example set wrong");
  addr_flag_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    !captured_reg && i_external_address_bus != pin_select_pkg::EXT_ADDR_DEFAULT |=> o_external_address_violation)
    else $error("address fight missed");

  // ==========================================================
  // Further checks on the selected owners
  // Configured states; each property waits one edge for the registered pins
  sequence eth_on_s;
    captured_reg && eth_sel_reg;
  endsequence
  sequence pci_on_s;
    captured_reg && pci_sel_reg;
  endsequence
  sequence pci_off_s;
    captured_reg && !pci_sel_reg;
  endsequence

  // MII transmit group is always driven once Ethernet owns it
  mii_drive_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    eth_on_s |=> o_host_port_data_oe[20:16] == 5'h1f) else $error("mii tx not driven");
  // Receive group reaches the controller unchanged
  mii_rx_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    eth_on_s |=> o_mii_rx_to_core[10:3] == $past(i_host_port_data_in[31:24]))
    else $error("mii rx not routed");
  // Host port keeps its enable while PCI is strapped off
  host_enable_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    pci_off_s |=> o_host_port_enable && !o_pci_enable) else $error("host port not enabled");
  // PCI strapped on: host port yields its enable
  pci_enable_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    pci_on_s |=> o_pci_enable && !o_host_port_enable) else $error("pci not enabled");
  // PCI core always sees the low group, whatever Ethernet takes
  pci_in_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    pci_on_s |=> o_pci_ad_to_core[15:0] == $past(i_host_port_data_in[15:0])) else $error("pci input lost");
  // Standalone PCI pins pass the core's enables only when PCI is on
  pci_solo_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    pci_on_s |=> o_pci_solo_oe == $past(i_pci_solo_oe)) else $error("pci pin enable lost");
  // Management pins stay quiet without the Ethernet strap
  mgmt_off_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
    captured_reg && !eth_sel_reg |=> !o_expansion_serial_clock_out && !o_expansion_serial_data_oe)
    else $error("management pin active");
endmodule // host_pci_mii_pin_select

//--- board_strap_model.sv
// Board-side model: strap resistors plus an outside agent on the address lines
`timescale 1ns/1ns
module board_strap_model (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [3:0] i_strap_req,
  input wire logic i_fight,
  output logic o_pci_select_strap,
  output logic o_ethernet_select_strap,
  output logic o_eeprom_autoinit_strap,
  output logic o_host_data_bit_five,
  output logic [18:0] o_external_address_bus
);
  // ==========================================================
  // Straps
  // Resistors only, so the level simply follows the board choice
  assign {o_pci_select_strap, o_ethernet_select_strap, o_eeprom_autoinit_strap, o_host_data_bit_five} = i_strap_req;
  // ==========================================================
  // Address agent
  logic [18:0] pattern_reg; // Free-running traffic once out of reset
  // Agent starts stepping its pattern only after reset is gone
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pattern_reg <= 19'h00000;
    end else begin
      pattern_reg <= pattern_reg + 19'h00001;
    end
  end
  // Defaults held during reset, busy traffic afterwards
  // A misbehaving agent (i_fight) drives the inverse of the defaults instead
  assign o_external_address_bus = i_fight ? ~pin_select_pkg::EXT_ADDR_DEFAULT
                                  : (i_reset_n ? pattern_reg : pin_select_pkg::EXT_ADDR_DEFAULT);
endmodule // board_strap_model

//--- host_pci_mii_pin_select_tb.sv
// Randomised self-checking bench for the shared pin selector
`timescale 1ns/1ns
module host_pci_mii_pin_select_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] req = 4'h0; // Board strap choice {pci, eth, eeprom, bit five}
  logic [31:0] din = 32'h0, hout = 32'h0, hoe = 32'h0, pout = 32'h0, poe = 32'h0, sel = 32'h0;
  logic [7:0] sout = 8'h0, soe = 8'h0;
  logic [4:0] tx = 5'h0;
  logic mc = 1'b0, md = 1'b0, mo = 1'b0;
  logic fight = 1'b0; // Outside agent breaks the address rule
  wire ps, es, ee, b5;
  wire [18:0] ab;
  logic [31:0] q_out, q_oe, q_hc, q_pc;
  logic [10:0] q_mii;
  logic [7:0] q_so, q_soe;
  logic q_xc, q_xd, q_xo, q_he, q_pe, q_ee, q_m, q_v;
  int bad_count = 0;
  int n_checks = 0;
  // Clock at 25 MHz
  always #20 i_clock = ~i_clock;
  board_strap_model board (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_strap_req(req), .i_fight(fight),
    .o_pci_select_strap(ps),
    .o_ethernet_select_strap(es), .o_eeprom_autoinit_strap(ee), .o_host_data_bit_five(b5), .o_external_address_bus(ab));
  host_pci_mii_pin_select uut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_pci_select_strap(ps),
    .i_ethernet_select_strap(es), .i_eeprom_autoinit_strap(ee), .i_host_data_bit_five(b5),
    .i_peripheral_select_register(sel), .i_host_port_data_in(din), .i_host_port_data_out(hout),
    .i_host_port_data_oe(hoe), .i_pci_ad_out(pout), .i_pci_ad_oe(poe), .i_mii_tx_out(tx), .i_pci_solo_out(sout),
    .i_pci_solo_oe(soe), .i_mgmt_clock(mc), .i_mgmt_data_out(md), .i_mgmt_data_oe(mo), .i_external_address_bus(ab),
    .o_host_port_data_out(q_out), .o_host_port_data_oe(q_oe), .o_host_port_data_to_core(q_hc),
    .o_pci_ad_to_core(q_pc), .o_mii_rx_to_core(q_mii), .o_pci_solo_out(q_so), .o_pci_solo_oe(q_soe),
    .o_expansion_serial_clock_out(q_xc), .o_expansion_serial_data_out(q_xd), .o_expansion_serial_data_oe(q_xo),
    .o_host_port_enable(q_he), .o_pci_enable(q_pe), .o_ethernet_controller_enable(q_ee),
    .o_example_config_match(q_m), .o_external_address_violation(q_v));
  // ==========================================================
  // Comparison and verdict
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================
  // One trial: reset with given straps, flip them after capture, then random traffic
  task automatic trial(input logic [3:0] r);
    logic [31:0] mm, ox;
    logic p, e;
    p = r[3];
    e = r[2];
    mm = e ? pin_select_pkg::MII_MASK : 32'h0;
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    req <= r;
    fight <= r[1] & r[0];
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(posedge i_clock);
    req <= ~r; // Late strap moves must stay invisible
    fight <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      {din, hout, hoe, pout, poe} <= {$urandom, $urandom, $urandom, $urandom, $urandom};
      {sout, soe, tx, mc, md, mo} <= 24'($urandom);
      sel <= (k < 2) ? pin_select_pkg::PERIPH_SELECT_EXAMPLE : $urandom;
      @(posedge i_clock);
      @(negedge i_clock);
      ox = ((p ? poe : hoe) & ~mm) | (e ? pin_select_pkg::MII_OUT_MASK : 32'h0);
      check("pin oe", q_oe, ox);
      check("pin out", q_out & ox, (((p ? pout : hout) & ~mm) | (e ? {11'h0, tx, 16'h0} : 32'h0)) & ox);
      check("host in", q_hc, p ? 32'h0 : din & ~mm);
      check("pci in", q_pc, p ? din & ~mm : 32'h0);
      check("mii in", {21'h0, q_mii}, e ? {21'h0, din[31:24], din[22:20]} : 32'h0);
      check("solo", {16'h0, q_so, q_soe}, p ? {16'h0, sout, soe} : 32'h0);
      check("enables", {29'h0, q_he, q_pe, q_ee}, {29'h0, !p, p, e});
      check("mgmt", {29'h0, q_xc, q_xd, q_xo}, e ? {29'h0, mc, md, mo} : 32'h0);
      check("example", {31'h0, q_m}, {31'h0, (r == 4'b0100) && (sel == pin_select_pkg::PERIPH_SELECT_EXAMPLE)});
      check("addr flag", {31'h0, q_v}, {31'h0, r[1] & r[0]});
      @(posedge i_clock);
    end
  endtask
  // ==========================================================
  // Main sequence: corner strap sets first, then random ones
  initial begin
    void'($urandom(55246));
    repeat (2) @(posedge i_clock);
    trial(4'b0100);
    trial(4'b1100);
    trial(4'b0000);
    trial(4'b1011);
    for (int t = 0; t < 24; t++) begin
      trial(4'($urandom));
    end
    final_report();
  end
  // Watchdog sized well past the roughly 600 cycles of traffic
  initial begin
    #200000;
    bad_count++;
    final_report();
  end
endmodule // host_pci_mii_pin_select_tb
